// ==== verilog/tbd_pkg.sv ====
package tbd_pkg;
    localparam int WORD_W = 12;
    localparam int OPC_W = 3;
    localparam int OFFS_W = 7;
    localparam int PAGE_W = WORD_W - OFFS_W;
    localparam int DEV_W = 6;
    localparam int NUM_STROBES = 3;

    // Field positions, numbered from the most significant bit as bit 0, except OPC_LSB, which counts from the least significant bit
    localparam int OPC_LSB = 9;
    localparam int DEV_LSB = 3;
    localparam int BIT_INDIRECT = 3;
    localparam int BIT_CURPAGE = 4;
    localparam int BIT_GROUP = 3;
    localparam int G1_CLR_ACC = 4;
    localparam int G1_CLR_LINK = 5;
    localparam int G1_CMP_ACC = 6;
    localparam int G1_CMP_LINK = 7;
    localparam int G1_ROT_RIGHT = 8;
    localparam int G1_ROT_LEFT = 9;
    localparam int G1_ROT_TWICE = 10;
    localparam int G1_INC_ACC = 11;
    localparam int G2_CLR_ACC = 4;
    localparam int G2_SKIP_MINUS = 5;
    localparam int G2_SKIP_ZERO = 6;
    localparam int G2_SKIP_LINK = 7;
    localparam int G2_SKIP_INVERT = 8;
    localparam int G2_OR_SWITCH = 9;
    localparam int G2_HALT = 10;

    localparam logic [OPC_W-1:0] OP_AND = 3'h0;
    localparam logic [OPC_W-1:0] OP_ADD = 3'h1;
    localparam logic [OPC_W-1:0] OP_ISZ = 3'h2;
    localparam logic [OPC_W-1:0] OP_STORE = 3'h3;
    localparam logic [OPC_W-1:0] OP_CALL = 3'h4;
    localparam logic [OPC_W-1:0] OP_JUMP = 3'h5;
    localparam logic [OPC_W-1:0] OP_IO = 3'h6;
    localparam logic [OPC_W-1:0] OP_OPERATE = 3'h7;

    localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
    localparam logic [PAGE_W-1:0] PAGE_ZERO = 5'h00;

    // Time states, numbered from zero
    localparam logic [1:0] TS_1 = 2'h0;
    localparam logic [1:0] TS_2 = 2'h1;
    localparam logic [1:0] TS_3 = 2'h2;
    localparam logic [1:0] TS_4 = 2'h3;

    localparam int CLK_NS = 10;
    localparam int CYCLE_NS = 1600;
    localparam int EXT_CYCLE_NS = 4250;
    localparam int EVENT_NS = 1000;
    localparam int CNT_W = 9;
    localparam int STATE_CLKS = CYCLE_NS / 4 / CLK_NS;
    localparam int EXTRA_CLKS = (EXT_CYCLE_NS - CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int EVENT_CLKS = EVENT_NS / CLK_NS;

    typedef enum logic [1:0] {MS_FETCH, MS_DEFER, MS_EXEC} tbd_major_t;
endpackage

// ==== verilog/tbd_ctl_if.sv ====
`timescale 1ns/1ps
interface tbd_ctl_if;
    logic [1:0] timeState;
    logic timePulse;
    logic run;
    logic pause;
    logic [tbd_pkg::NUM_STROBES-1:0] ioBits;
    logic [tbd_pkg::NUM_STROBES-1:0] strobes;

    modport timing (output timeState, output timePulse, input run, input pause);
    modport strobe (input pause, input ioBits, output strobes);
    modport core (input timeState, input timePulse, output run, output pause,
        output ioBits, input strobes);
endinterface

// ==== verilog/tbd_time_states.sv ====
`timescale 1ns/1ps
module tbd_time_states (
    input wire logic clk,
    input wire logic nrst,
    tbd_ctl_if.timing ctl
);
    typedef struct packed {
        logic [1:0] ts;
        logic [tbd_pkg::CNT_W-1:0] cnt;
    } tbd_time_t;

    tbd_time_t s_reg;
    tbd_time_t s_next;
    logic [tbd_pkg::CNT_W-1:0] stateLen;

    // Third state stretches so strobes finish inside one fetch
    assign stateLen = (ctl.pause && s_reg.ts == tbd_pkg::TS_3)
        ? tbd_pkg::CNT_W'(tbd_pkg::STATE_CLKS + tbd_pkg::EXTRA_CLKS)
        : tbd_pkg::CNT_W'(tbd_pkg::STATE_CLKS);
    assign ctl.timePulse = ctl.run && (s_reg.cnt == stateLen - 1'b1);
    assign ctl.timeState = s_reg.ts;

    always_comb
    begin
        s_next = s_reg;
        if (!ctl.run)
        begin
            s_next.ts = tbd_pkg::TS_1;
            s_next.cnt = '0;
        end
        else if (ctl.timePulse)
        begin
            s_next.cnt = '0;
            s_next.ts = s_reg.ts + 2'h1;
        end
        else
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
endmodule

// ==== verilog/tbd_io_strobes.sv ====
`timescale 1ns/1ps
module tbd_io_strobes (
    input wire logic clk,
    input wire logic nrst,
    tbd_ctl_if.strobe ctl
);
    typedef struct packed {
        logic active;
        logic done;
        logic [1:0] evt;
        logic [tbd_pkg::CNT_W-1:0] cnt;
        logic [tbd_pkg::NUM_STROBES-1:0] out;
    } tbd_strobe_t;

    tbd_strobe_t s_reg;
    tbd_strobe_t s_next;

    assign ctl.strobes = s_reg.out;

    always_comb
    begin
        s_next = s_reg;
        s_next.out = '0;
        if (!ctl.pause)
        begin
            s_next.active = 1'b0;
            s_next.done = 1'b0;
        end
        else if (!s_reg.active && !s_reg.done)
        begin
            s_next.active = 1'b1;
            s_next.evt = 2'h0;
            s_next.cnt = '0;
        end
        else if (s_reg.active)
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
            if (s_reg.cnt == tbd_pkg::CNT_W'(tbd_pkg::EVENT_CLKS - 1))
            begin
                // One pulse per event time, only when its bit asks
                s_next.cnt = '0;
                s_next.out[s_reg.evt] = ctl.ioBits[s_reg.evt];
                s_next.evt = s_reg.evt + 2'h1;
                if (s_reg.evt == 2'(tbd_pkg::NUM_STROBES - 1))
                begin
                    s_next.active = 1'b0;
                    s_next.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
endmodule

// ==== verilog/tbd_decode_core.sv ====
`timescale 1ns/1ps
// Behaviour
// - Opcode in top three bits
// - Offset with current page or page zero
// - Indirect bit fetches full pointer first
// - Two or three cycles; jump one/two
// - AND into accumulator, word restored
// - Add; carry out flips link
// - Increment word, skip when zero
// - Store accumulator then clear it
// - Store return address, continue at target+1
// - Jump loads effective address into counter
// - Augmented ops finish in one fetch
// - Opcode six sets pause, stretches fetch
// - Up to three strobes, one microsecond apart
// - Device code from bits three to eight
// - Bit three picks operate group
// - Complement inverted, increment with carry
// - Increments, complement and several buffer loads through one gating network
// - Opcode latched from sense during fetch
// - Next major state entered at end pulse
// - Four time states with pulses
module tbd_decode_core (
    input wire logic clk,
    input wire logic nrst,
    output logic [tbd_pkg::WORD_W-1:0] memAddr,
    output logic [tbd_pkg::WORD_W-1:0] memWrData,
    output logic memWrite,
    input wire logic [tbd_pkg::WORD_W-1:0] memRdData,
    input wire logic [tbd_pkg::WORD_W-1:0] frontSwitchWord,
    input wire logic [tbd_pkg::WORD_W-1:0] ioDataIn,
    input wire logic ioLoadAcc,
    input wire logic startKey,
    output logic [tbd_pkg::DEV_W-1:0] ioDeviceCode,
    output logic [tbd_pkg::NUM_STROBES-1:0] ioStrobePulse,
    output logic [tbd_pkg::WORD_W-1:0] ioBusData,
    output logic [tbd_pkg::WORD_W-1:0] workRegister,
    output logic linkBit,
    output logic [tbd_pkg::WORD_W-1:0] programCounter,
    output logic [tbd_pkg::OPC_W-1:0] opcodeLatch,
    output logic [1:0] majorState,
    output logic running,
    output logic pauseFlag
);
    localparam int W = tbd_pkg::WORD_W;

    typedef struct packed {
        tbd_pkg::tbd_major_t major;
        logic [W-1:0] acc;
        logic link;
        logic [W-1:0] pc;
        logic [W-1:0] mb;
        logic [W-1:0] ma;
        logic [W-1:0] sense;
        logic [tbd_pkg::OPC_W-1:0] opc;
        logic pause;
        logic run;
        logic [W-1:0] swMeta;
        logic [W-1:0] swSync;
        logic [W-1:0] inMeta;
        logic [W-1:0] inSync;
        logic [1:0] ctlMeta;
        logic [1:0] ctlSync;
    } tbd_core_t;

    tbd_core_t s_reg;
    tbd_core_t s_next;

    ////////////////////////////////////////////////////////////////////
    // Shared helpers

    // Bit n counted from the most significant end
    function automatic logic ibit(input logic [W-1:0] w, input int n);
        ibit = w[W-1-n];
    endfunction

    // One adder serves increments, complement and several buffer loads: invert, pass, or carry in
    function automatic logic [W:0] gateNet(input logic [W-1:0] src,
        input logic inv, input logic cin);
        logic [W:0] sum;
        sum = {1'b0, (inv ? ~src : src)} + {{W{1'b0}}, cin};
        gateNet = sum;
    endfunction

    function automatic logic [W-1:0] effAddr(input logic [W-1:0] ins,
        input logic [W-1:0] insAddr);
        logic [tbd_pkg::PAGE_W-1:0] page;
        page = ibit(ins, tbd_pkg::BIT_CURPAGE)
            ? insAddr[W-1:tbd_pkg::OFFS_W] : tbd_pkg::PAGE_ZERO;
        effAddr = {page, ins[tbd_pkg::OFFS_W-1:0]};
    endfunction

    // First operate group, in its fixed internal sequence
    function automatic logic [W:0] operateOne(input logic [W-1:0] ins,
        input logic [W-1:0] acc, input logic link);
        logic [W:0] r;
        logic [W:0] inc;
        r = {link, acc};
        if (ibit(ins, tbd_pkg::G1_CLR_ACC))
            r[W-1:0] = tbd_pkg::WORD_ZERO;
        if (ibit(ins, tbd_pkg::G1_CLR_LINK))
            r[W] = 1'b0;
        if (ibit(ins, tbd_pkg::G1_CMP_ACC))
            r[W-1:0] = W'(gateNet(r[W-1:0], 1'b1, 1'b0));
        if (ibit(ins, tbd_pkg::G1_CMP_LINK))
            r[W] = ~r[W];
        if (ibit(ins, tbd_pkg::G1_INC_ACC))
        begin
            inc = gateNet(r[W-1:0], 1'b0, 1'b1);
            r = {r[W] ^ inc[W], inc[W-1:0]};
        end
        // Right and left together conflict; right then wins here
        if (ibit(ins, tbd_pkg::G1_ROT_RIGHT))
        begin
            r = {r[0], r[W:1]};
            if (ibit(ins, tbd_pkg::G1_ROT_TWICE))
                r = {r[0], r[W:1]};
        end
        else if (ibit(ins, tbd_pkg::G1_ROT_LEFT))
        begin
            r = {r[W-1:0], r[W]};
            if (ibit(ins, tbd_pkg::G1_ROT_TWICE))
                r = {r[W-1:0], r[W]};
        end
        operateOne = r;
    endfunction

    function automatic logic skipTest(input logic [W-1:0] ins,
        input logic [W-1:0] acc, input logic link);
        logic cond;
        cond = (ibit(ins, tbd_pkg::G2_SKIP_MINUS) && acc[W-1])
            || (ibit(ins, tbd_pkg::G2_SKIP_ZERO) && acc == tbd_pkg::WORD_ZERO)
            || (ibit(ins, tbd_pkg::G2_SKIP_LINK) && link);
        skipTest = ibit(ins, tbd_pkg::G2_SKIP_INVERT) ? ~cond : cond;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Timing and strobe helpers

    tbd_ctl_if ctl ();

    tbd_time_states timeGen (
        .clk(clk),
        .nrst(nrst),
        .ctl(ctl.timing)
    );

    tbd_io_strobes strobeGen (
        .clk(clk),
        .nrst(nrst),
        .ctl(ctl.strobe)
    );

    logic atPulse;
    logic [1:0] ts;
    logic [W-1:0] ea;
    logic [W:0] sum;
    logic [W:0] opOne;
    logic [W-1:0] pcNext;

    assign atPulse = ctl.timePulse;
    assign ts = ctl.timeState;
    assign ctl.run = s_reg.run;
    assign ctl.pause = s_reg.pause;
    assign ctl.ioBits = {s_reg.mb[2], s_reg.mb[1], s_reg.mb[0]};
    assign ea = effAddr(s_reg.mb, s_reg.ma);
    assign sum = gateNet(s_reg.acc, 1'b0, 1'b0)
        + {1'b0, s_reg.sense};
    assign opOne = operateOne(s_reg.mb, s_reg.acc, s_reg.link);
    assign pcNext = W'(gateNet(s_reg.pc, 1'b0, 1'b1));

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign memAddr = s_reg.ma;
    assign memWrData = s_reg.mb;
    // Core reads are destructive, so every cycle writes the buffer back
    assign memWrite = atPulse && ts == tbd_pkg::TS_4;
    assign ioDeviceCode = s_reg.mb[W-1-tbd_pkg::DEV_LSB -: tbd_pkg::DEV_W];
    assign ioStrobePulse = ctl.strobes;
    assign ioBusData = s_reg.acc;
    assign workRegister = s_reg.acc;
    assign linkBit = s_reg.link;
    assign programCounter = s_reg.pc;
    assign opcodeLatch = s_reg.opc;
    assign majorState = s_reg.major;
    assign running = s_reg.run;
    assign pauseFlag = s_reg.pause;

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_next = s_reg;
        s_next.swMeta = frontSwitchWord;
        s_next.swSync = s_reg.swMeta;
        s_next.inMeta = ioDataIn;
        s_next.inSync = s_reg.inMeta;
        s_next.ctlMeta = {startKey, ioLoadAcc};
        s_next.ctlSync = s_reg.ctlMeta;
        if (!s_reg.run && s_reg.ctlSync[1])
        begin
            s_next.run = 1'b1;
            s_next.major = tbd_pkg::MS_FETCH;
            s_next.ma = s_reg.pc;
        end
        if (atPulse)
        begin
            case (ts)
                tbd_pkg::TS_1:
                begin
                    s_next.sense = memRdData;
                end
                tbd_pkg::TS_2:
                begin
                    s_next.mb = W'(gateNet(s_reg.sense, 1'b0, 1'b0));
                    if (s_reg.major == tbd_pkg::MS_FETCH)
                    begin
                        s_next.opc = s_reg.sense[W-1:tbd_pkg::OPC_LSB];
                        s_next.pc = pcNext;
                        if (s_reg.sense[W-1:tbd_pkg::OPC_LSB] == tbd_pkg::OP_IO)
                            s_next.pause = 1'b1;
                    end
                end
                tbd_pkg::TS_3:
                begin
                    if (s_reg.major == tbd_pkg::MS_EXEC)
                    begin
                        case (s_reg.opc)
                            tbd_pkg::OP_ISZ:
                                s_next.mb = W'(gateNet(s_reg.sense, 1'b0, 1'b1));
                            tbd_pkg::OP_STORE:
                                s_next.mb = W'(gateNet(s_reg.acc, 1'b0, 1'b0));
                            tbd_pkg::OP_CALL:
                                s_next.mb = W'(gateNet(s_reg.pc, 1'b0, 1'b0));
                            default:
                                s_next.mb = s_reg.sense;
                        endcase
                    end
                end
                tbd_pkg::TS_4:
                begin
                    case (s_reg.major)
                        tbd_pkg::MS_FETCH:
                        begin
                            if (s_reg.opc <= tbd_pkg::OP_JUMP)
                            begin
                                s_next.ma = ea;
                                if (ibit(s_reg.mb, tbd_pkg::BIT_INDIRECT))
                                    s_next.major = tbd_pkg::MS_DEFER;
                                else if (s_reg.opc == tbd_pkg::OP_JUMP)
                                begin
                                    s_next.pc = ea;
                                    s_next.major = tbd_pkg::MS_FETCH;
                                end
                                else
                                    s_next.major = tbd_pkg::MS_EXEC;
                            end
                            else if (s_reg.opc == tbd_pkg::OP_IO)
                            begin
                                if (s_reg.ctlSync[0])
                                    s_next.acc = s_reg.acc | s_reg.inSync;
                                s_next.pause = 1'b0;
                                s_next.ma = s_reg.pc;
                            end
                            else if (!ibit(s_reg.mb, tbd_pkg::BIT_GROUP))
                            begin
                                s_next.acc = opOne[W-1:0];
                                s_next.link = opOne[W];
                                s_next.ma = s_reg.pc;
                            end
                            else
                            begin
                                if (ibit(s_reg.mb, tbd_pkg::G2_CLR_ACC))
                                    s_next.acc = tbd_pkg::WORD_ZERO;
                                if (ibit(s_reg.mb, tbd_pkg::G2_OR_SWITCH))
                                    s_next.acc = s_next.acc | s_reg.swSync;
                                if (ibit(s_reg.mb, tbd_pkg::G2_HALT))
                                    s_next.run = 1'b0;
                                if (skipTest(s_reg.mb, s_reg.acc, s_reg.link))
                                begin
                                    s_next.pc = pcNext;
                                    s_next.ma = pcNext;
                                end
                                else
                                    s_next.ma = s_reg.pc;
                            end
                        end
                        tbd_pkg::MS_DEFER:
                        begin
                            // The pointer word is the full operand address
                            s_next.ma = s_reg.sense;
                            if (s_reg.opc == tbd_pkg::OP_JUMP)
                            begin
                                s_next.pc = s_reg.sense;
                                s_next.major = tbd_pkg::MS_FETCH;
                            end
                            else
                                s_next.major = tbd_pkg::MS_EXEC;
                        end
                        tbd_pkg::MS_EXEC:
                        begin
                            s_next.major = tbd_pkg::MS_FETCH;
                            s_next.ma = s_reg.pc;
                            case (s_reg.opc)
                                tbd_pkg::OP_AND:
                                    s_next.acc = s_reg.acc & s_reg.sense;
                                tbd_pkg::OP_ADD:
                                begin
                                    s_next.acc = sum[W-1:0];
                                    s_next.link = s_reg.link ^ sum[W];
                                end
                                tbd_pkg::OP_ISZ:
                                begin
                                    if (s_reg.mb == tbd_pkg::WORD_ZERO)
                                    begin
                                        s_next.pc = pcNext;
                                        s_next.ma = pcNext;
                                    end
                                end
                                tbd_pkg::OP_STORE:
                                    s_next.acc = tbd_pkg::WORD_ZERO;
                                tbd_pkg::OP_CALL:
                                begin
                                    s_next.pc = W'(gateNet(s_reg.ma, 1'b0, 1'b1));
                                    s_next.ma = s_next.pc;
                                end
                                default:
                                    s_next.ma = s_reg.pc;
                            endcase
                        end
                        default:
                            s_next.major = tbd_pkg::MS_FETCH;
                    endcase
                end
                default:
                    s_next.sense = s_reg.sense;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_reg <= '0;
            s_reg.run <= 1'b1;
        end
        else
            s_reg <= s_next;
    end
endmodule

// ==== bench/tbd_decode_props.sv ====
`timescale 1ns/1ps
module tbd_decode_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [11:0] memAddr,
    input wire logic [11:0] memWrData,
    input wire logic memWrite,
    input wire logic [11:0] memRdData,
    input wire logic [5:0] ioDeviceCode,
    input wire logic [2:0] ioStrobePulse,
    input wire logic [11:0] workRegister,
    input wire logic [11:0] programCounter,
    input wire logic [2:0] opcodeLatch,
    input wire logic [1:0] majorState,
    input wire logic pauseFlag
);
    logic [8:0] gapCount_reg;
    wire logic [11:0] prevPc = programCounter - 12'h001;
    // Clocks since last write; one figure per cycle kind
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            gapCount_reg <= 9'h000;
        else
            gapCount_reg <= memWrite ? 9'h000 : gapCount_reg + 9'h001;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_fetchEnd;
        memWrite && majorState == 2'h0;
    endsequence
    sequence s_memRef;
        s_fetchEnd ##0 opcodeLatch < 3'h6;
    endsequence
    // Window allows for the strobe register stage
    sequence s_ioStart;
        $rose(pauseFlag) && opcodeLatch == 3'h6;
    endsequence
    chk_cycle_len: assert property (
        memWrite |-> gapCount_reg inside {9'h09f, 9'h1a8}) else $error("cycle length wrong");
    chk_page_addr: assert property (s_memRef |=> memAddr[6:0] == $past(memWrData[6:0])
        && memAddr[11:7] == ($past(memWrData[7]) ? $past(prevPc[11:7]) : 5'h00))
        else $error("effective address wrong");
    chk_next_state: assert property (s_memRef |=> majorState ==
        ($past(memWrData[8]) ? 2'h1 : ($past(opcodeLatch) == 3'h5 ? 2'h0 : 2'h2)))
        else $error("next major state wrong");
    chk_augment_one: assert property (s_fetchEnd ##0 opcodeLatch >= 3'h6
        |=> majorState == 2'h0) else $error("augmented op left fetch");
    chk_defer_ptr: assert property (memWrite && majorState == 2'h1
        |=> memAddr == $past(memWrData)) else $error("pointer not used");
    chk_and_restore: assert property (memWrite && majorState == 2'h2
        && opcodeLatch == 3'h0 |-> memWrData == memRdData) else $error("word not restored");
    chk_store_clear: assert property (memWrite && majorState == 2'h2
        && opcodeLatch == 3'h3 |=> workRegister == 12'h000) else $error("acc not cleared");
    chk_io_code: assert property (pauseFlag |-> opcodeLatch == 3'h6
        && ioDeviceCode == memRdData[8:3]) else $error("device code wrong");
    chk_strobe_one: assert property (ioStrobePulse != 3'h0
        |-> pauseFlag && $onehot(ioStrobePulse)) else $error("stray strobe");
    chk_event_first: assert property (s_ioStart
        |-> ##[99:103] ioStrobePulse[0] == memWrData[0]) else $error("event one wrong");
    chk_event_third: assert property (s_ioStart
        |-> ##[299:303] ioStrobePulse[2] == memWrData[2]) else $error("event three wrong");
endmodule

// ==== bench/tbd_mem_model.sv ====
`timescale 1ns/1ps
module tbd_mem_model #(parameter logic [5:0] SEL_CODE = 6'h2a) (
    input wire logic clk,
    input wire logic [11:0] memAddr,
    input wire logic [11:0] memWrData,
    input wire logic memWrite,
    output logic [11:0] memRdData,
    input wire logic [5:0] ioDeviceCode,
    input wire logic [2:0] ioStrobePulse,
    output logic [2:0] devicePulse
);
    logic [11:0] store [0:4095];
    assign memRdData = store[memAddr];
    // Other selectors ignore the shared strobes
    assign devicePulse = (ioDeviceCode == SEL_CODE) ? ioStrobePulse : 3'h0;
    // Plain always: the bench preloads this array by hierarchy
    always @(posedge clk)
    begin
        if (memWrite)
            store[memAddr] <= memWrData;
    end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    logic clk, nrst, ioLoadAcc, startKey, memWrite, linkBit, running, pauseFlag;
    logic [11:0] frontSwitchWord, ioDataIn, memRdData, memAddr, memWrData;
    logic [11:0] workRegister, programCounter, r1, r2, mask, got, want, ioBusData;
    logic [5:0] ioDeviceCode;
    logic [2:0] ioStrobePulse, opcodeLatch, devicePulse;
    logic [1:0] majorState;
    logic [12:0] sum;
    logic [7:0] devCount = 8'h00;
    logic runPrev = 1'b0;
    logic [11:0] notes [$];
    int num_errors = 0;
    int checked = 0;
    // Bits 8 and 9 never set together in group one
    localparam logic [23:0] PROG [0:12] = '{24'h000240, 24'h001241, 24'h002042, 24'h003b43,
        24'h0430c8, 24'h0c84d0, 24'h0c9f02, 24'h0d0fff, 24'h0ca644, 24'h0cb845,
        24'h046d55, 24'h047e20, 24'h048f46};
    tbd_decode_core uut (.clk, .nrst, .memAddr, .memWrData, .memWrite, .memRdData,
        .frontSwitchWord, .ioDataIn, .ioLoadAcc, .startKey, .ioDeviceCode, .ioStrobePulse,
        .ioBusData, .workRegister, .linkBit, .programCounter, .opcodeLatch, .majorState,
        .running, .pauseFlag);
    tbd_mem_model peer (.clk, .memAddr, .memWrData, .memWrite, .memRdData, .ioDeviceCode,
        .ioStrobePulse, .devicePulse);
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end
    // Strobe events and the halt each retire one note
    always @(posedge clk)
    begin
        if (nrst === 1'b1 && (ioStrobePulse !== 3'h0 || (runPrev === 1'b1 && running === 1'b0)))
        begin
            got = (ioStrobePulse !== 3'h0) ? {9'h000, ioStrobePulse} : programCounter;
            want = (notes.size() > 0) ? notes.pop_front() : 12'hxxx;
            `CHECK(got, want)
        end
        runPrev <= running;
        devCount <= devCount + 8'($countones(devicePulse));
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        ioLoadAcc = 1'b0;
        startKey = 1'b0;
        void'($urandom(32'h3418));
        frontSwitchWord = 12'($urandom());
        ioDataIn = 12'($urandom());
        r1 = 12'($urandom());
        r2 = 12'($urandom());
        mask = 12'($urandom());
        for (int i = 0; i < 4096; i++)
            peer.store[i] = 12'h000;
        foreach (PROG[i])
            peer.store[PROG[i][23:12]] = PROG[i][11:0];
        peer.store[12'h040] = r1;
        peer.store[12'h041] = r2;
        peer.store[12'h042] = mask;
        sum = {1'b0, r1} + {1'b0, r2};
        // Skip on minus sees the inverted input word, so bit 11 picks the halt address
        notes = '{12'h001, 12'h004, ioDataIn[11] ? 12'h049 : 12'h04a};
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        ioLoadAcc <= 1'b1;
        for (int i = 0; i < 6000 && running !== 1'b0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        `CHECK(peer.store[12'h044], sum[11:0] & mask)
        `CHECK(peer.store[12'h040], r1)
        `CHECK(peer.store[12'h045], 12'h0cc)
        `CHECK(peer.store[12'h0d0], 12'h000)
        `CHECK(linkBit, sum[12])
        `CHECK(workRegister, ~ioDataIn | frontSwitchWord)
        `CHECK(ioBusData, ~ioDataIn | frontSwitchWord)
        `CHECK(running, 1'b0)
        `CHECK(devCount, 8'h02)
        `CHECK(12'(notes.size()), 12'h000)
        stop_test();
    end
endmodule
bind tbd_decode_core tbd_decode_props chk (.clk(clk), .nrst(nrst), .memAddr(memAddr),
    .memWrData(memWrData), .memWrite(memWrite), .memRdData(memRdData),
    .ioDeviceCode(ioDeviceCode), .ioStrobePulse(ioStrobePulse), .workRegister(workRegister),
    .programCounter(programCounter), .opcodeLatch(opcodeLatch), .majorState(majorState),
    .pauseFlag(pauseFlag));
